// [src/cmp_vref_pkg.sv]
// Package with register map, field layout and shared types for the comparator and reference.
package cmp_vref_pkg;

   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // Register indices; the byte address equals the index on this plain port.
   localparam logic [3:0] OFF_CMP_CTRL  = 4'h0;
   localparam logic [3:0] OFF_VREF_CTRL = 4'h1;
   localparam logic [3:0] OFF_IRQ_CTRL  = 4'h2;
   localparam logic [3:0] OFF_PORT_CFG  = 4'h3;
   localparam logic [3:0] OFF_PORT_DIR  = 4'h4;

   // Comparator control fields.
   localparam int CMP_RES2_BIT = 7;
   localparam int CMP_RES1_BIT = 6;
   localparam int CMP_INV2_BIT = 5;
   localparam int CMP_INV1_BIT = 4;
   localparam int CMP_SWITCH_BIT = 3;
   localparam int CMP_MODE_LSB = 0;
   localparam int CMP_MODE_W = 3;
   localparam logic [2:0] CMP_MODE_OFF = 3'h7;
   localparam logic [2:0] CMP_MODE_INTREF = 3'h6;

   // Reference control fields.
   localparam int VREF_EN_BIT = 7;
   localparam int VREF_OE_BIT = 6;
   localparam int VREF_RANGE_BIT = 5;
   localparam int VREF_SRC_BIT = 4;
   localparam int VREF_LEVEL_LSB = 0;
   localparam int VREF_LEVEL_W = 4;
   localparam logic [7:0] VREF_RESET = 8'h00;

   // Interrupt control fields.
   localparam int IRQ_FLAG_BIT = 0;
   localparam int IRQ_EN_BIT = 1;

   // Port configuration and direction.
   localparam int PCFG_W = 4;
   localparam logic [3:0] PCFG_RESET = 4'h0;
   localparam int REF_PIN_DIR_BIT = 5;
   localparam logic [7:0] PORT_DIR_RESET = 8'hff;

   typedef struct packed {
      logic       enable;
      logic       pinDrive;
      logic       lowRange;
      logic       extSource;
      logic [3:0] level;
   } ladder_ctrl_s;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_s;

endpackage : cmp_vref_pkg

// [src/change_detect.sv]
// Edge detector for one comparator result with a registered previous value.
`timescale 1ns/1ps
module change_detect
(
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic clkEn,
   input  wire logic level,
   output logic      changed
);
   logic prev_r;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         prev_r <= 1'b0;
      else if (clkEn)
         prev_r <= level;
   end

   assign changed = clkEn && (prev_r != level);

endmodule : change_detect

// [src/pin_role_map.sv]
// Maps the analog port configuration field onto the four comparator input pins.
`timescale 1ns/1ps
module pin_role_map
(
   input  wire logic [3:0] portCfg,
   output logic [3:0]      analogPins
);
   // Codes at or below a pin's threshold keep it analog; reset code 0 makes all four analog.
   always_comb
   begin
      for (int i = 0; i < 4; i++)
         analogPins[i] = (portCfg <= 4'(11 - i));
   end

endmodule : pin_role_map

// [src/comparator_vref_control.sv]
// Register file and digital control for the dual comparator and its reference ladder.
`timescale 1ns/1ps
module comparator_vref_control
(
   input  wire logic                      ref_clk,
   input  wire logic                      rst,
   input  wire logic                      clkEn,
   input  wire logic                      sleeping,
   input  wire logic                      cmpOneRaw,
   input  wire logic                      cmpTwoRaw,
   input  wire cmp_vref_pkg::reg_req_s    regReq,
   output logic [7:0]                     rdData,
   output cmp_vref_pkg::ladder_ctrl_s     ladderCtrl,
   output logic [2:0]                     comparatorModeField,
   output logic                           comparatorInputSwitch,
   output logic                           comparatorsOn,
   output logic                           comparatorOneResult,
   output logic                           comparatorTwoResult,
   output logic                           referenceOutputPinOe_n,
   output logic [3:0]                     analogPins,
   output logic                           wakeReq,
   output logic                           irqReq
);
   typedef struct packed {
      logic [7:0]                 cmpCtrl;
      cmp_vref_pkg::ladder_ctrl_s vref;
      logic                       flag;
      logic                       irqEn;
      logic [3:0]                 portCfg;
      logic [7:0]                 portDir;
      logic [7:0]                 rdData;
      logic                       pinOe_n;
      logic [3:0]                 analogPins;
      logic                       wake;
      logic                       irq;
      logic                       cmpOn;
   } state_s;

   state_s state_r;
   state_s state_nxt;

   logic       oneChg;
   logic       twoChg;
   logic       res1;
   logic       res2;
   logic [3:0] pinRoles;
   logic       wrCmp;
   logic       wrVref;
   logic       wrIrq;
   logic       wrCfg;
   logic       wrDir;
   logic [2:0] modeNow;

   // Inverted results are what software and the change detector see.
   assign res1 = cmpOneRaw ^ state_r.cmpCtrl[cmp_vref_pkg::CMP_INV1_BIT];
   assign res2 = cmpTwoRaw ^ state_r.cmpCtrl[cmp_vref_pkg::CMP_INV2_BIT];

   change_detect u_chgOne
   (
      .ref_clk (ref_clk),
      .rst     (rst),
      .clkEn   (clkEn),
      .level   (res1),
      .changed (oneChg)
   );

   change_detect u_chgTwo
   (
      .ref_clk (ref_clk),
      .rst     (rst),
      .clkEn   (clkEn),
      .level   (res2),
      .changed (twoChg)
   );

   pin_role_map u_pins
   (
      .portCfg    (state_r.portCfg),
      .analogPins (pinRoles)
   );

   assign wrCmp  = regReq.wr && (regReq.addr == cmp_vref_pkg::OFF_CMP_CTRL);
   assign wrVref = regReq.wr && (regReq.addr == cmp_vref_pkg::OFF_VREF_CTRL);
   assign wrIrq  = regReq.wr && (regReq.addr == cmp_vref_pkg::OFF_IRQ_CTRL);
   assign wrCfg  = regReq.wr && (regReq.addr == cmp_vref_pkg::OFF_PORT_CFG);
   assign wrDir  = regReq.wr && (regReq.addr == cmp_vref_pkg::OFF_PORT_DIR);
   assign modeNow = state_r.cmpCtrl[cmp_vref_pkg::CMP_MODE_LSB +: cmp_vref_pkg::CMP_MODE_W];

   always_comb
   begin
      logic modeOff;
      modeOff = 1'b0;
      state_nxt = state_r;
      // Sleep is deliberately not an input to any register update except the wake request.
      if (wrCmp)
      begin
         state_nxt.cmpCtrl[cmp_vref_pkg::CMP_INV2_BIT:0] =
            regReq.wdata[cmp_vref_pkg::CMP_INV2_BIT:0];
      end
      state_nxt.cmpCtrl[cmp_vref_pkg::CMP_RES1_BIT] = res1;
      state_nxt.cmpCtrl[cmp_vref_pkg::CMP_RES2_BIT] = res2;
      if (wrVref)
      begin
         state_nxt.vref = cp_vref(regReq.wdata);
      end
      if (wrIrq)
      begin
         state_nxt.flag  = regReq.wdata[cmp_vref_pkg::IRQ_FLAG_BIT];
         state_nxt.irqEn = regReq.wdata[cmp_vref_pkg::IRQ_EN_BIT];
      end
      if (wrCfg)
      begin
         state_nxt.portCfg = regReq.wdata[cmp_vref_pkg::PCFG_W-1:0];
      end
      if (wrDir)
      begin
         state_nxt.portDir = regReq.wdata;
      end
      modeOff = (modeNow == cmp_vref_pkg::CMP_MODE_OFF);
      // A change wins over a software clear in the same cycle.
      if ((oneChg || twoChg) && !modeOff)
      begin
         state_nxt.flag = 1'b1;
      end
      // Pin drive overrides the direction bit.
      state_nxt.pinOe_n = !(state_nxt.vref.pinDrive ||
                            !state_nxt.portDir[cmp_vref_pkg::REF_PIN_DIR_BIT]);
      state_nxt.analogPins = pinRoles;
      // The power state is registered so that the output comes straight from a flop.
      state_nxt.cmpOn = (state_nxt.cmpCtrl[cmp_vref_pkg::CMP_MODE_LSB +: cmp_vref_pkg::CMP_MODE_W]
                         != cmp_vref_pkg::CMP_MODE_OFF);
      // Comparators run during sleep; the enabled flag wakes the device.
      state_nxt.wake = state_nxt.flag && state_nxt.irqEn && sleeping;
      state_nxt.irq  = state_nxt.flag && state_nxt.irqEn;
      state_nxt.rdData = 8'h00;
      if (regReq.rd)
      begin
         unique case (regReq.addr)
            cmp_vref_pkg::OFF_CMP_CTRL:  state_nxt.rdData = state_r.cmpCtrl;
            cmp_vref_pkg::OFF_VREF_CTRL: state_nxt.rdData = state_r.vref;
            cmp_vref_pkg::OFF_IRQ_CTRL:
               state_nxt.rdData = {6'h00, state_r.irqEn, state_r.flag};
            cmp_vref_pkg::OFF_PORT_CFG:  state_nxt.rdData = {4'h0, state_r.portCfg};
            cmp_vref_pkg::OFF_PORT_DIR:  state_nxt.rdData = state_r.portDir;
            default:                     state_nxt.rdData = 8'h00;
         endcase
      end
   end

   function automatic cmp_vref_pkg::ladder_ctrl_s cp_vref(input logic [7:0] d);
      cmp_vref_pkg::ladder_ctrl_s v;
      v.enable    = d[cmp_vref_pkg::VREF_EN_BIT];
      v.pinDrive  = d[cmp_vref_pkg::VREF_OE_BIT];
      v.lowRange  = d[cmp_vref_pkg::VREF_RANGE_BIT];
      v.extSource = d[cmp_vref_pkg::VREF_SRC_BIT];
      v.level     = d[cmp_vref_pkg::VREF_LEVEL_LSB +: cmp_vref_pkg::VREF_LEVEL_W];
      return v;
   endfunction : cp_vref

   // Reset state: mode off, reference cleared, pins analog, direction all input.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         state_r            <= '0;
         state_r.cmpCtrl    <= {5'h00, cmp_vref_pkg::CMP_MODE_OFF};
         state_r.vref       <= cmp_vref_pkg::VREF_RESET;
         state_r.portCfg    <= cmp_vref_pkg::PCFG_RESET;
         state_r.portDir    <= cmp_vref_pkg::PORT_DIR_RESET;
         state_r.pinOe_n    <= 1'b1;
         state_r.analogPins <= '1;
      end
      else if (clkEn)
      begin
         state_r <= state_nxt;
      end
   end

   // Reference fields do not look at comparator state.
   assign ladderCtrl            = state_r.vref;
   assign rdData                = state_r.rdData;
   assign comparatorModeField   = modeNow;
   assign comparatorInputSwitch = state_r.cmpCtrl[cmp_vref_pkg::CMP_SWITCH_BIT];
   assign comparatorsOn         = state_r.cmpOn;
   assign comparatorOneResult   = state_r.cmpCtrl[cmp_vref_pkg::CMP_RES1_BIT];
   assign comparatorTwoResult   = state_r.cmpCtrl[cmp_vref_pkg::CMP_RES2_BIT];
   assign referenceOutputPinOe_n = state_r.pinOe_n;
   assign analogPins            = state_r.analogPins;
   assign wakeReq               = state_r.wake;
   assign irqReq                = state_r.irq;

   property p_vref_write;
      @(posedge ref_clk) disable iff (rst)
      (clkEn && wrVref) |=> (ladderCtrl == $past(regReq.wdata));
   endproperty
   a_vref_write: assert property (p_vref_write) else $error("reference write lost");

   property p_range;
      @(posedge ref_clk) disable iff (rst)
      (clkEn && wrVref) |=>
         (ladderCtrl.lowRange == $past(regReq.wdata[cmp_vref_pkg::VREF_RANGE_BIT]));
   endproperty
   a_range: assert property (p_range) else $error("range bit misplaced");

   property p_flag_set;
      @(posedge ref_clk) disable iff (rst)
      (clkEn && (oneChg || twoChg) && comparatorsOn) |=> state_r.flag;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("change flag not set");

   property p_sleep_hold;
      @(posedge ref_clk) disable iff (rst)
      (sleeping && !regReq.wr) |=> (ladderCtrl == $past(ladderCtrl)) &&
         (comparatorModeField == $past(comparatorModeField));
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("control changed in sleep");

   property p_pin_oe;
      @(posedge ref_clk) disable iff (rst)
      (clkEn && wrVref && regReq.wdata[cmp_vref_pkg::VREF_OE_BIT]) |=> !referenceOutputPinOe_n;
   endproperty
   a_pin_oe: assert property (p_pin_oe) else $error("reference pin not driven");

   property p_wake;
      @(posedge ref_clk) disable iff (rst)
      (clkEn && sleeping && state_r.irqEn && (oneChg || twoChg) && comparatorsOn && !wrIrq)
         ##1 (clkEn && sleeping && !wrIrq) |=> wakeReq;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake on change");

   property p_mode_reset;
      @(posedge ref_clk) $fell(rst) |-> (comparatorModeField == cmp_vref_pkg::CMP_MODE_OFF) &&
         (ladderCtrl == cmp_vref_pkg::VREF_RESET) && (&analogPins);
   endproperty
   a_mode_reset: assert property (p_mode_reset) else $error("bad reset state");

   property p_indep;
      @(posedge ref_clk) disable iff (rst)
      (clkEn && wrVref && !comparatorsOn) |=>
         (ladderCtrl.enable == $past(regReq.wdata[cmp_vref_pkg::VREF_EN_BIT]));
   endproperty
   a_indep: assert property (p_indep) else $error("reference tied to comparators");

   // Holds: only a completed write may move a setting, so sleep or a stray strobe cannot.
   property p_cmp_hold;
      @(posedge ref_clk) disable iff (rst)
      !(clkEn && wrCmp) |=> $stable(comparatorModeField) && $stable(comparatorInputSwitch);
   endproperty
   a_cmp_hold: assert property (p_cmp_hold) else $error("comparator control moved");

   property p_vref_hold;
      @(posedge ref_clk) disable iff (rst)
      !(clkEn && wrVref) |=> $stable(ladderCtrl);
   endproperty
   a_vref_hold: assert property (p_vref_hold) else $error("reference control moved");

   property p_level_write;
      @(posedge ref_clk) disable iff (rst)
      (clkEn && wrVref) |=> (ladderCtrl.level ==
         $past(regReq.wdata[cmp_vref_pkg::VREF_LEVEL_LSB +: cmp_vref_pkg::VREF_LEVEL_W]));
   endproperty
   a_level_write: assert property (p_level_write) else $error("level field lost");

   property p_level_read;
      @(posedge ref_clk) disable iff (rst)
      (clkEn && regReq.rd && (regReq.addr == cmp_vref_pkg::OFF_VREF_CTRL)) |=>
         (rdData[cmp_vref_pkg::VREF_LEVEL_LSB +: cmp_vref_pkg::VREF_LEVEL_W] ==
          $past(ladderCtrl.level));
   endproperty
   a_level_read: assert property (p_level_read) else $error("level readback wrong");

   property p_source;
      @(posedge ref_clk) disable iff (rst)
      (clkEn && wrVref) |=>
         (ladderCtrl.extSource == $past(regReq.wdata[cmp_vref_pkg::VREF_SRC_BIT]));
   endproperty
   a_source: assert property (p_source) else $error("source bit misplaced");

   property p_enable;
      @(posedge ref_clk) disable iff (rst)
      (clkEn && wrVref) |=>
         (ladderCtrl.enable == $past(regReq.wdata[cmp_vref_pkg::VREF_EN_BIT]));
   endproperty
   a_enable: assert property (p_enable) else $error("enable bit misplaced");

   property p_pin_release;
      @(posedge ref_clk) disable iff (rst)
      (clkEn && wrVref && !regReq.wdata[cmp_vref_pkg::VREF_OE_BIT] &&
       state_r.portDir[cmp_vref_pkg::REF_PIN_DIR_BIT]) |=> referenceOutputPinOe_n;
   endproperty
   a_pin_release: assert property (p_pin_release) else $error("reference pin left driven");

   property p_on_state;
      @(posedge ref_clk) disable iff (rst)
      comparatorsOn == (comparatorModeField != cmp_vref_pkg::CMP_MODE_OFF);
   endproperty
   a_on_state: assert property (p_on_state) else $error("comparator power state wrong");

   // With both comparators off a result edge is noise and must not raise the flag.
   property p_off_quiet;
      @(posedge ref_clk) disable iff (rst)
      (clkEn && !comparatorsOn && !wrIrq) |=> (state_r.flag == $past(state_r.flag));
   endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("change flagged while off");

   property p_pins_reset;
      @(posedge ref_clk) disable iff (rst)
      (clkEn && (state_r.portCfg == cmp_vref_pkg::PCFG_RESET)) |=> (&analogPins);
   endproperty
   a_pins_reset: assert property (p_pins_reset) else $error("pins not analog");

   property p_wake_awake;
      @(posedge ref_clk) disable iff (rst)
      (clkEn && !sleeping) |=> !wakeReq;
   endproperty
   a_wake_awake: assert property (p_wake_awake) else $error("wake while awake");

   property p_wake_irq;
      @(posedge ref_clk) disable iff (rst)
      wakeReq |-> irqReq;
   endproperty
   a_wake_irq: assert property (p_wake_irq) else $error("wake without interrupt");

   c_wake: cover property (@(posedge ref_clk) disable iff (rst) $rose(wakeReq));
   c_vref: cover property (@(posedge ref_clk) disable iff (rst) clkEn && wrVref);
   c_flag: cover property (@(posedge ref_clk) disable iff (rst) $rose(irqReq));
   c_sleep_chg: cover property (@(posedge ref_clk) disable iff (rst) sleeping && oneChg);
   c_hold: cover property (@(posedge ref_clk) disable iff (rst) !clkEn && regReq.wr);

endmodule : comparator_vref_control

// [verif/tb_top.sv]
// Self-checking bench for the comparator and reference control block.
`timescale 1ns/1ps
module tb_top;
   logic                       ref_clk = 1'b0;
   logic                       rst = 1'b1;
   logic                       clkEn = 1'b1;
   logic                       sleeping = 1'b0;
   logic                       rawOne = 1'b0;
   logic                       rawTwo = 1'b0;
   cmp_vref_pkg::reg_req_s     req = '0;
   logic [7:0]                 rdData;
   cmp_vref_pkg::ladder_ctrl_s ladder;
   logic [2:0]                 mode;
   logic                       inSw, cmpOn, resOne, resTwo, pinOe_n, wake, irq;
   logic [3:0]                 aPins;
   logic [7:0]                 cmpM, vrefM, d;
   logic [3:0]                 cfgM;
   bit                         hold = 1'b0;
   int                         failures = 0;
   int                         num_checks = 0;
   int                         i;

   comparator_vref_control comparator_vref_control_inst
   (
      .ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .sleeping(sleeping),
      .cmpOneRaw(rawOne), .cmpTwoRaw(rawTwo), .regReq(req), .rdData(rdData),
      .ladderCtrl(ladder), .comparatorModeField(mode), .comparatorInputSwitch(inSw),
      .comparatorsOn(cmpOn), .comparatorOneResult(resOne), .comparatorTwoResult(resTwo),
      .referenceOutputPinOe_n(pinOe_n), .analogPins(aPins), .wakeReq(wake), .irqReq(irq)
   );

   always #4 ref_clk = ~ref_clk;

   task automatic tally_and_finish;
      if (failures == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   function automatic logic [3:0] pinsExp(input int c);
      for (int k = 0; k < 4; k++)
         pinsExp[k] = (c <= 11 - k);
   endfunction : pinsExp

   // The model only takes a write when the clock enable was high at the taking edge.
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      req.addr <= a;
      req.wdata <= v;
      req.wr <= 1'b1;
      clkEn <= !hold;
      @(posedge ref_clk);
      req.wr <= 1'b0;
      clkEn <= 1'b1;
      if (!hold && a == 4'h0)
         cmpM = {2'h0, v[5:0]};
      if (!hold && a == 4'h1)
         vrefM = v;
      if (!hold && a == 4'h3)
         cfgM = v[3:0];
      #1;
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge ref_clk);
      req.rd <= 1'b0;
      #1;
      chk(rdData, exp);
   endtask : rd

   task automatic chkOut;
      chk(ladder, vrefM);
      chk({5'h0, mode}, {5'h0, cmpM[2:0]});
      chk({7'h0, cmpOn}, {7'h0, cmpM[2:0] != 3'h7});
      chk({7'h0, pinOe_n}, {7'h0, !vrefM[6]});
      chk({4'h0, aPins}, {4'h0, pinsExp(cfgM)});
      chk({7'h0, inSw}, {7'h0, cmpM[3]});
   endtask : chkOut

   task automatic resetCheck;
      cmpM = 8'h07;
      vrefM = 8'h00;
      cfgM = 4'h0;
      chkOut();
      rd(4'h0, 8'h07);
      rd(4'h1, 8'h00);
      rd(4'h2, 8'h00);
   endtask : resetCheck

   // A wait that runs out is counted and ends the run.
   task automatic waitHigh(input bit useWake);
      for (int n = 0; n < 10; n++)
      begin
         @(posedge ref_clk);
         #1;
         if ((useWake ? wake : irq) === 1'b1)
            return;
      end
      $display("CHECK FAILED at %0t: wait ran out", $time);
      failures++;
      tally_and_finish();
   endtask : waitHigh

   initial
   begin
      void'($urandom(32'h0f83));
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      #1;
      resetCheck();
      for (i = 0; i < 10; i++)
      begin
         d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
         wr(4'h1, d);
         chkOut();
         rd(4'h1, d);
      end
      for (i = 0; i < 8; i++)
      begin
         wr(4'h0, 8'(i) | 8'h08);
         chkOut();
      end
      @(posedge ref_clk);
      rawOne <= 1'b1;
      rawTwo <= 1'b1;
      wr(4'h0, 8'hf0);
      rd(4'h0, 8'h30);
      wr(4'h2, 8'h02);
      @(posedge ref_clk);
      rawOne <= 1'b0;
      waitHigh(1'b0);
      rd(4'h2, 8'h03);
      chk({6'h0, resTwo, resOne}, {6'h0, ~rawTwo, ~rawOne});
      wr(4'h2, 8'h00);
      @(posedge ref_clk);
      rawTwo <= 1'b0;
      repeat (4) @(posedge ref_clk);
      #1;
      rd(4'h2, 8'h01);
      chk({7'h0, irq}, 8'h00);
      @(posedge ref_clk);
      sleeping <= 1'b1;
      wr(4'h2, 8'h02);
      chk({7'h0, wake}, 8'h00);
      // A result change during sleep, not a software write, must raise the wake.
      @(posedge ref_clk);
      rawOne <= 1'b1;
      waitHigh(1'b1);
      rd(4'h0, 8'hb0);
      rd(4'h1, vrefM);
      chkOut();
      // Software turns both blocks off while the device is still asleep.
      wr(4'h2, 8'h00);
      wr(4'h0, 8'h07);
      wr(4'h1, 8'h00);
      @(posedge ref_clk);
      rawOne <= 1'b0;
      repeat (4) @(posedge ref_clk);
      #1;
      chk({7'h0, wake}, 8'h00);
      rd(4'h2, 8'h00);
      @(posedge ref_clk);
      sleeping <= 1'b0;
      for (i = 0; i < 16; i++)
      begin
         wr(4'h3, 8'(i));
         @(posedge ref_clk);
         #1;
         chk({4'h0, aPins}, {4'h0, pinsExp(i)});
      end
      wr(4'h1, 8'h40);
      wr(4'h4, 8'h00);
      chk({7'h0, pinOe_n}, 8'h00);
      wr(4'h4, 8'hff);
      wr(4'hf, 8'hff);
      rd(4'hf, 8'h00);
      chkOut();
      hold = 1'b1;
      wr(4'h1, 8'h5a);
      hold = 1'b0;
      rd(4'h1, vrefM);
      @(posedge ref_clk);
      rst <= 1'b1;
      rawOne <= 1'b0;
      @(posedge ref_clk);
      rst <= 1'b0;
      #1;
      resetCheck();
      tally_and_finish();
   end
endmodule : tb_top
